// ---- rtl/fpt_flat_panel_timing.sv ----
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module fpt_flat_panel_timing
#(
	parameter int CLK_MHZ = fpt_pkg::SYS_CLK_MHZ
)
(
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [fpt_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// pixel source
	input  wire logic [15:0]              pixData,
	output logic                          pixTake,
	// panel
	output logic                          dotClock,
	output logic                          lineSync,
	output logic                          frameSync,
	output logic                          displayActive,
	output logic                          pixelValid,
	output logic                          lampSwitch,
	output logic      [5:0]               red,
	output logic      [5:0]               green,
	output logic      [5:0]               blue,
	// analogue monitor sync
	output logic                          monLineSync,
	output logic                          monFrameSync
);
	import fpt_pkg::*;

	localparam logic [8:0] CLK_LIM = 9'(CLK_MHZ);

	//----------------------------------------------------------------
	// functions
	//----------------------------------------------------------------
	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				res[i*8 +: 8] = dat[i*8 +: 8];
		end
		return res;
	endfunction

	function automatic logic [HCNT_W-1:0] resWidth(input logic [1:0] res);
		case (res)
			RES_800:  return W800;
			RES_1024: return W1024;
			default:  return W640;
		endcase
	endfunction

	function automatic logic [VCNT_W-1:0] resHeight(input logic [1:0] res);
		case (res)
			RES_800:  return H600;
			RES_1024: return H768;
			default:  return H480;
		endcase
	endfunction

	function automatic logic [HCNT_W-1:0] hUnits(input logic [SET_W-1:0] s);
		return HCNT_W'({s, 3'b000});
	endfunction

	function automatic logic [VCNT_W-1:0] vUnits(input logic [SET_W-1:0] s);
		return VCNT_W'(s);
	endfunction

	// 16bpp is 5:6:5, 8bpp is 3:3:2; low bits replicate msbs
	function automatic logic [17:0] expandPix(input logic [15:0] p, input logic deep);
		if (deep)
			return {p[15:11], p[15], p[10:5], p[4:0], p[4]};
		return {p[7:5], p[7:5], p[4:2], p[4:2], p[1:0], p[1:0], p[1:0]};
	endfunction

	//----------------------------------------------------------------
	// registers
	//----------------------------------------------------------------
	logic [31:0]       ctrl_r;
	logic [31:0]       dotMhz_r;
	logic [31:0]       lineSet_r;
	logic [31:0]       frameSet_r;
	logic [31:0]       rdData;
	logic              busReq;
	logic [HCNT_W-1:0] hCount_r;
	logic [VCNT_W-1:0] vCount_r;
	logic              panelOn;

	assign busReq  = wb_cyc_i & wb_stb_i;
	assign panelOn = (ctrl_r[CTRL_TYPE_LSB +: 2] == TYPE_CUSTOM);

	always_comb
	begin
		rdData = 32'h0000_0000;
		case (wb_adr_i)
			REG_CTRL:   rdData = ctrl_r;
			REG_DOTCLK: rdData = dotMhz_r;
			REG_LINE:   rdData = lineSet_r;
			REG_FRAME:  rdData = frameSet_r;
			REG_STATUS:
			begin
				rdData[STAT_HCNT_LSB +: HCNT_W] = hCount_r;
				rdData[STAT_VCNT_LSB +: VCNT_W] = vCount_r;
				rdData[STAT_VVIS] = (vCount_r < resHeight(ctrl_r[CTRL_RES_LSB +: 2]));
			end
			default:    rdData = 32'h0000_0000;
		endcase
	end

	// one wait state: ack rises one edge after the request
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= busReq & ~wb_ack_o;
			wb_dat_o <= rdData;
		end
	end

	// writes land at the edge where the master sees ack
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r     <= CTRL_RESET;
			dotMhz_r   <= DOTCLK_RESET;
			lineSet_r  <= LINE_RESET;
			frameSet_r <= FRAME_RESET;
		end
		else if (busReq && wb_ack_o && wb_we_i)
		begin
			case (wb_adr_i)
				REG_CTRL:   ctrl_r     <= mergeBytes(ctrl_r, wb_dat_i, wb_sel_i);
				REG_DOTCLK: dotMhz_r   <= mergeBytes(dotMhz_r, wb_dat_i, wb_sel_i);
				REG_LINE:   lineSet_r  <= mergeBytes(lineSet_r, wb_dat_i, wb_sel_i);
				REG_FRAME:  frameSet_r <= mergeBytes(frameSet_r, wb_dat_i, wb_sel_i);
				default:    ;
			endcase
		end
	end

	//----------------------------------------------------------------
	// pixel clock divider
	//----------------------------------------------------------------
	// phase accumulator toggles the clock; above half mclk it saturates
	logic [8:0] halfStep;
	logic [8:0] phaseSum;
	logic [8:0] phase_r;
	logic       dotClk_r;
	logic       wrap;
	logic       pixEn;

	always_comb
	begin
		halfStep = {dotMhz_r[7:0], 1'b0};
		if (halfStep > CLK_LIM)
			halfStep = CLK_LIM;
		phaseSum = phase_r + halfStep;
	end

	assign wrap  = panelOn && (phaseSum >= CLK_LIM) && (halfStep != 9'h000);
	assign pixEn = wrap & dotClk_r;  // falling edge: data settles before the rise

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_r  <= 9'h000;
			dotClk_r <= 1'b0;
		end
		else if (!panelOn)
		begin
			phase_r  <= 9'h000;
			dotClk_r <= 1'b0;
		end
		else if (wrap)
		begin
			phase_r  <= phaseSum - CLK_LIM;
			dotClk_r <= ~dotClk_r;
		end
		else
			phase_r <= phaseSum;
	end

	assign dotClock = dotClk_r;

	//----------------------------------------------------------------
	// line and frame counters
	//----------------------------------------------------------------
	logic [HCNT_W-1:0] hVisW;
	logic [HCNT_W-1:0] hSyncOn;
	logic [HCNT_W-1:0] hSyncOff;
	logic [HCNT_W-1:0] hTotal;
	logic [VCNT_W-1:0] vVisH;
	logic [VCNT_W-1:0] vSyncOn;
	logic [VCNT_W-1:0] vSyncOff;
	logic [VCNT_W-1:0] vTotal;
	logic              hVis;
	logic              vVis;
	logic              hSyn;
	logic              vSyn;

	always_comb
	begin
		hVisW    = resWidth(ctrl_r[CTRL_RES_LSB +: 2]);
		vVisH    = resHeight(ctrl_r[CTRL_RES_LSB +: 2]);
		hSyncOn  = hVisW + hUnits(lineSet_r[FRONT_LSB +: SET_W]);
		hSyncOff = hSyncOn + hUnits(lineSet_r[WIDTH_LSB +: SET_W]);
		hTotal   = hSyncOff + hUnits(lineSet_r[BACK_LSB +: SET_W]);
		vSyncOn  = vVisH + vUnits(frameSet_r[FRONT_LSB +: SET_W]);
		vSyncOff = vSyncOn + vUnits(frameSet_r[WIDTH_LSB +: SET_W]);
		vTotal   = vSyncOff + vUnits(frameSet_r[BACK_LSB +: SET_W]);
		hVis     = hCount_r < hVisW;
		vVis     = vCount_r < vVisH;
		hSyn     = (hCount_r >= hSyncOn) && (hCount_r < hSyncOff);
		vSyn     = (vCount_r >= vSyncOn) && (vCount_r < vSyncOff);
	end

	// >= wrap keeps counters sane when settings shrink mid-frame
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hCount_r <= '0;
			vCount_r <= '0;
		end
		else if (!panelOn)
		begin
			hCount_r <= '0;
			vCount_r <= '0;
		end
		else if (pixEn)
		begin
			if (hCount_r >= hTotal - 13'h0001)
			begin
				hCount_r <= '0;
				if (vCount_r >= vTotal - 11'h001)
					vCount_r <= '0;
				else
					vCount_r <= vCount_r + 11'h001;
			end
			else
				hCount_r <= hCount_r + 13'h0001;
		end
	end

	//----------------------------------------------------------------
	// panel outputs
	//----------------------------------------------------------------
	logic [17:0] pixRgb;
	logic        linePol;
	logic        framePol;

	assign pixRgb   = expandPix(pixData, ctrl_r[CTRL_DEEP]);
	assign linePol  = ctrl_r[CTRL_LPOL];
	assign framePol = ctrl_r[CTRL_FPOL];
	assign pixTake  = pixEn & hVis & vVis;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lineSync      <= 1'b1;
			frameSync     <= 1'b1;
			displayActive <= 1'b0;
			pixelValid    <= 1'b0;
			red           <= 6'h00;
			green         <= 6'h00;
			blue          <= 6'h00;
			monLineSync   <= 1'b1;
			monFrameSync  <= 1'b1;
		end
		else if (!panelOn)
		begin
			lineSync      <= ~linePol;
			frameSync     <= ~framePol;
			displayActive <= 1'b0;
			pixelValid    <= 1'b0;
			red           <= 6'h00;
			green         <= 6'h00;
			blue          <= 6'h00;
			monLineSync   <= ~linePol;
			monFrameSync  <= ~framePol;
		end
		else if (pixEn)
		begin
			lineSync      <= hSyn ~^ linePol;
			frameSync     <= vSyn ~^ framePol;
			displayActive <= hVis & vVis;
			pixelValid    <= hVis & vVis;
			red           <= (hVis & vVis) ? pixRgb[17:12] : 6'h00;
			green         <= (hVis & vVis) ? pixRgb[11:6] : 6'h00;
			blue          <= (hVis & vVis) ? pixRgb[5:0] : 6'h00;
			monLineSync   <= ctrl_r[CTRL_MON] ? (hSyn ~^ linePol) : ~linePol;
			monFrameSync  <= ctrl_r[CTRL_MON] ? (vSyn ~^ framePol) : ~framePol;
		end
	end

	assign lampSwitch = ctrl_r[CTRL_LAMP];

endmodule

// ---- rtl/fpt_pkg.sv ----
// Summary of operation
// - continuous pixel clock drives every pixel
// - three 6-bit colour buses, msb highest
// - line sync sets line rate, retrace
// - frame sync sets refresh, vertical retrace
// - display active only in visible pixels
// - pixel valid marks cycles with data
// - host controls backlight lamp switch output
// - line = visible + front + sync + back
// - frame = visible + front + sync + back
// - horizontal settings count eight pixel clocks
// - vertical settings count whole lines unscaled
// - supports 640x480, 800x600, 1024x768 at 8/16bpp
// - resolution selects size, defaults to 640x480
// - pixel clock programmable in whole megahertz
// - panel type defaults disabled; custom enables
// - panel timing also governs monitor sync
package fpt_pkg;

	//----------------------------------------------------------------
	// system clock
	//----------------------------------------------------------------
	localparam int SYS_CLK_PERIOD_NS = 20;
	localparam int SYS_CLK_MHZ       = 1000 / SYS_CLK_PERIOD_NS;

	//----------------------------------------------------------------
	// register offsets (byte addresses)
	//----------------------------------------------------------------
	localparam int         ADR_W      = 8;
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_DOTCLK = 8'h04;
	localparam logic [7:0] REG_LINE   = 8'h08;
	localparam logic [7:0] REG_FRAME  = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;

	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [31:0] DOTCLK_RESET = 32'h0000_0000;
	localparam logic [31:0] LINE_RESET   = 32'h0000_0000;
	localparam logic [31:0] FRAME_RESET  = 32'h0000_0000;

	//----------------------------------------------------------------
	// control fields
	//----------------------------------------------------------------
	localparam int CTRL_TYPE_LSB  = 0;
	localparam int CTRL_RES_LSB   = 2;
	localparam int CTRL_LAMP      = 4;
	localparam int CTRL_LPOL      = 5;
	localparam int CTRL_FPOL      = 6;
	localparam int CTRL_DEEP      = 7;
	localparam int CTRL_MON       = 8;

	localparam logic [1:0] TYPE_DISABLED = 2'h0;
	localparam logic [1:0] TYPE_CUSTOM   = 2'h1;

	localparam logic [1:0] RES_640  = 2'h0;
	localparam logic [1:0] RES_800  = 2'h1;
	localparam logic [1:0] RES_1024 = 2'h2;

	//----------------------------------------------------------------
	// timing fields and sizes
	//----------------------------------------------------------------
	localparam int FRONT_LSB = 0;
	localparam int WIDTH_LSB = 8;
	localparam int BACK_LSB  = 16;
	localparam int SET_W     = 8;
	localparam int H_SHIFT   = 3;
	localparam int HCNT_W    = 13;
	localparam int VCNT_W    = 11;

	localparam logic [HCNT_W-1:0] W640  = 13'h0280;
	localparam logic [HCNT_W-1:0] W800  = 13'h0320;
	localparam logic [HCNT_W-1:0] W1024 = 13'h0400;
	localparam logic [VCNT_W-1:0] H480  = 11'h1E0;
	localparam logic [VCNT_W-1:0] H600  = 11'h258;
	localparam logic [VCNT_W-1:0] H768  = 11'h300;

	localparam int STAT_HCNT_LSB = 0;
	localparam int STAT_VCNT_LSB = 16;
	localparam int STAT_VVIS     = 28;

endpackage

// ---- dv/fpt_timing_assertions.sv ----
`timescale 1ns/1ps
module fpt_timing_assertions
#(
	parameter int CLK_MHZ = 50
)
(
	// clock, reset and bus
	input wire logic	mclk,
	input wire logic	rst_n,
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_we_i,
	input wire logic [fpt_pkg::ADR_W-1:0]	wb_adr_i,
	input wire logic [3:0]	wb_sel_i,
	input wire logic [31:0]	wb_dat_i,
	input wire logic	wb_ack_o,
	// panel
	input wire logic	pixTake,
	input wire logic	dotClock,
	input wire logic	lineSync,
	input wire logic	frameSync,
	input wire logic	displayActive,
	input wire logic	pixelValid,
	input wire logic	lampSwitch,
	input wire logic [5:0]	red,
	input wire logic [5:0]	green,
	input wire logic [5:0]	blue
);
	import fpt_pkg::*;
	logic	isCustom_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// shadow of the panel type where a control write lands
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			isCustom_r <= 1'b0;
		else if (wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0])
			isCustom_r <= wb_dat_i[1:0] == TYPE_CUSTOM;
	sequence sReq;
		$rose(wb_cyc_i && wb_stb_i) && !wb_ack_o;
	endsequence
	sequence sAck;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	AST_ACK: assert property (sReq |=> sAck)
		else $error("ack late or long");
	AST_BLANK: assert property (!displayActive |-> {red, green, blue} == 18'h0_0000)
		else $error("colour in blanking");
	AST_VALID: assert property (pixelValid == displayActive)
		else $error("valid differs from active");
	AST_TAKE: assert property (pixTake |=> displayActive && $fell(dotClock))
		else $error("taken pixel not shown on clock fall");
	AST_LAMP: assert property ($changed(lampSwitch) |-> $past(wb_ack_o) && $past(wb_we_i))
		else $error("lamp moved without write");
	AST_STOP: assert property ((!isCustom_r) [*3] |-> !dotClock && !displayActive)
		else $error("panel runs while off");
	AST_ACT: assert property ($changed(displayActive) |-> $fell(dotClock) || !isCustom_r)
		else $error("active off clock fall");
	AST_LSYNC: assert property ($changed(lineSync) |-> $fell(dotClock) || !isCustom_r)
		else $error("line sync off clock fall");
	AST_FSYNC: assert property ($changed(frameSync) |-> $fell(dotClock) || !isCustom_r)
		else $error("frame sync off clock fall");
endmodule
bind fpt_flat_panel_timing fpt_timing_assertions #(.CLK_MHZ(CLK_MHZ)) uChk
(
	.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .pixTake(pixTake), .dotClock(dotClock), .lineSync(lineSync),
	.frameSync(frameSync), .displayActive(displayActive), .pixelValid(pixelValid),
	.lampSwitch(lampSwitch), .red(red), .green(green), .blue(blue)
);

// ---- dv/fpt_panel_model.sv ----
`timescale 1ns/1ps
module fpt_panel_model
(
	// panel link
	input wire logic	dotClock,
	input wire logic	lineSync,
	input wire logic	displayActive,
	input wire logic	syncHigh,
	// last full line, in pixel clocks; lines counts line syncs
	output logic [12:0]	lineLen,
	output logic [12:0]	actLen,
	output logic [12:0]	syncLen,
	output logic [12:0]	frontLen,
	output logic [15:0]	lines
);
	logic [12:0]	cnt, act, syn, fr;
	logic	inSync, wasSync;
	assign inSync = lineSync == syncHigh;
	initial
	begin
		lines = 16'h0000;
		wasSync = 1'b0;
	end
	// panel samples on the rising pixel clock
	always @(posedge dotClock)
	begin
		wasSync <= inSync;
		fr <= displayActive ? 13'h0000 : fr + 13'(!inSync);
		if (inSync && !wasSync)
		begin
			lineLen <= cnt;
			actLen <= act;
			syncLen <= syn;
			frontLen <= fr;
			cnt <= 13'h0001;
			act <= 13'h0000;
			syn <= 13'h0001;
			lines <= lines + 16'h0001;
		end
		else
		begin
			cnt <= cnt + 13'h0001;
			act <= act + 13'(displayActive);
			syn <= syn + 13'(inSync);
		end
	end
endmodule

// ---- dv/flat_panel_timing_tb.sv ----
`timescale 1ns/1ps
module flat_panel_timing_tb;
	import fpt_pkg::*;
	logic	mclk, rst_n, cyc, stb, we, ack, syncHigh;
	logic	dotClock, lineSync, frameSync, dispAct, pixValid, lamp;
	logic	take, deepBit, colDue, monLine, monFrame;
	logic [17:0]	expRgb;
	logic [7:0]	adr, f, s, b;
	logic [3:0]	sel;
	logic [31:0]	wdat, q, rdat, ctl;
	logic [15:0]	pixData, lines, n0;
	logic [12:0]	lineLen, actLen, syncLen, frontLen;
	logic [5:0]	red, green, blue;
	logic [7:0]	regs [5] = '{REG_CTRL, REG_DOTCLK, REG_LINE, REG_FRAME, 8'h40};
	int	errors, checkCount, seed, cycles;
	time	t0;
	fpt_flat_panel_timing DUT
	(
		.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(q), .wb_ack_o(ack),
		.pixData(pixData), .pixTake(take), .dotClock(dotClock), .lineSync(lineSync),
		.frameSync(frameSync), .displayActive(dispAct), .pixelValid(pixValid),
		.lampSwitch(lamp), .red(red), .green(green), .blue(blue),
		.monLineSync(monLine), .monFrameSync(monFrame)
	);
	fpt_panel_model uPanel
	(
		.dotClock(dotClock), .lineSync(lineSync), .displayActive(dispAct),
		.syncHigh(syncHigh), .lineLen(lineLen), .actLen(actLen), .syncLen(syncLen),
		.frontLen(frontLen), .lines(lines)
	);
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		pixData <= 16'($random(seed));
		cycles <= cycles + 1;
		// a taken pixel shows on the colour buses one edge later
		colDue <= take;
		expRgb <= rgbExp(pixData, deepBit);
		if (colDue)
			chk(32'({red, green, blue}), 32'(expRgb));
		if (cycles == 60000)
		begin
			errors++;
			give_verdict();
		end
	end
	// 16bpp is 5:6:5, 8bpp is 3:3:2 in the low byte; msbs fill the low bits
	function automatic logic [17:0] rgbExp(input logic [15:0] p, input logic d);
		if (d)
			return {p[15:11], p[15], p[10:5], p[4:0], p[4]};
		return {{2{p[7:5]}}, {2{p[4:2]}}, {3{p[1:0]}}};
	endfunction
	function automatic logic [12:0] visW(input logic [1:0] r);
		return r == RES_800 ? W800 : r == RES_1024 ? W1024 : W640;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
		@(posedge mclk);
		while (ack !== 1'b1)
			@(posedge mclk);
		rdat = q;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic give_verdict();
		$display("errors=%0d checks=%0d", errors, checkCount);
		if (errors == 0 && checkCount > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		{seed, errors, checkCount, cycles} = {32'd5271, 96'd0};
		{rst_n, cyc, stb, we, adr, sel, wdat, pixData, syncHigh, deepBit, colDue} = '0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (regs[i])
		begin
			wb(1'b0, regs[i], 32'h0000_0000);
			chk(rdat, 32'h0000_0000);
		end
		wb(1'b0, REG_STATUS, 32'h0000_0000);
		chk(rdat, 32'h0000_0001 << STAT_VVIS);
		for (int v = 1; v >= 0; v--)
		begin
			wb(1'b1, REG_CTRL, 32'(v << CTRL_LAMP));
			@(posedge mclk);
			chk(32'(lamp), 32'(v));
		end
		for (int m = 5; m <= 25; m += 20)
		begin
			wb(1'b1, REG_DOTCLK, 32'(m));
			wb(1'b1, REG_CTRL, 32'(TYPE_CUSTOM));
			repeat (2) @(posedge dotClock);
			t0 = $time;
			@(posedge dotClock);
			chk(32'(($time - t0) / 20), 32'(SYS_CLK_MHZ / m));
		end
		for (int r = 0; r < 4; r++)
		begin
			f = 8'(1 + ($random(seed) & 3));
			s = 8'(1 + ($random(seed) & 3));
			b = 8'(1 + ($random(seed) & 3));
			ctl = 32'($random(seed)) & 32'h0000_01E0 | 32'(r << CTRL_RES_LSB);
			wb(1'b1, REG_CTRL, ctl);
			wb(1'b1, REG_LINE, {8'h00, b, s, f});
			wb(1'b1, REG_FRAME, 32'($random(seed)) & 32'h00FF_FFFF);
			wb(1'b0, REG_LINE, 32'h0000_0000);
			chk(rdat, {8'h00, b, s, f});
			syncHigh = ctl[CTRL_LPOL];
			wb(1'b1, REG_CTRL, ctl | 32'(TYPE_CUSTOM));
			deepBit = ctl[CTRL_DEEP];
			n0 = lines;
			wait (lines == n0 + 16'h0002);
			// in line sync of a visible line: frame sync idle, monitor copy follows enable
			chk(32'({monLine, frameSync, monFrame}), 32'({ctl[CTRL_MON] ? ctl[CTRL_LPOL] : !ctl[CTRL_LPOL], !ctl[CTRL_FPOL], !ctl[CTRL_FPOL]}));
			chk(32'(lineLen), 32'(visW(r[1:0])) + 8 * (f + s + b));
			chk(32'(actLen), 32'(visW(r[1:0])));
			chk(32'(syncLen), 8 * s);
			chk(32'(frontLen), 8 * f);
		end
		give_verdict();
	end
endmodule
